//--- design/mmc_ctrl_word.sv
`timescale 1ns/1ps
`default_nettype none
module mmc_ctrl_word (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        wr_en,
   input  wire logic [15:0] wr_data,
   output logic      [15:0] rd_data,
   output logic             msg_on
);
   logic       en_r;
   logic       en_nxt;
   logic [2:0] alloc_r;
   logic [2:0] alloc_nxt;
   always_comb begin
      en_nxt    = en_r;
      alloc_nxt = alloc_r;
      if (wr_en) begin
         en_nxt    = wr_data[mmc_pkg::CTRL_ENABLE_BIT];
         // host keeps the count legal; stored as written
         alloc_nxt = wr_data[mmc_pkg::CTRL_ALLOC_LSB +: 3];
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         en_r    <= mmc_pkg::ENABLE_RESET;
         alloc_r <= mmc_pkg::ALLOC_RESET;
      end else begin
         en_r    <= en_nxt;
         alloc_r <= alloc_nxt;
      end
   end
   // upper byte zero, wide flag one, requested code fixed
   assign rd_data = {8'h00, mmc_pkg::WIDE_CAPABLE, alloc_r,
                     mmc_pkg::REQ_ONE_VECTOR, en_r};
   assign msg_on  = en_r;
endmodule
`default_nettype wire

//--- design/mmc_data_reg.sv
`timescale 1ns/1ps
`default_nettype none
module mmc_data_reg #(
   parameter int          WIDTH = 32,
   parameter logic [31:0] WMASK = 32'hFFFF_FFFF,
   parameter logic [31:0] RSTV  = 32'h0000_0000
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             wr_en,
   input  wire logic [WIDTH-1:0] wr_data,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] q_r;
   logic [WIDTH-1:0] q_nxt;
   always_comb begin
      q_nxt = q_r;
      if (wr_en) begin
         q_nxt = wr_data & WMASK[WIDTH-1:0];
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         q_r <= RSTV[WIDTH-1:0];
      end else begin
         q_r <= q_nxt;
      end
   end
   assign q = q_r;
endmodule
`default_nettype wire

//--- design/mmc_msi_cap.sv
// How it works
// - control word upper byte reads zero; writes there are dropped
// - wide-address capable flag is fixed at one
// - allocated-vector field is zero after reset
// - requested-vector field is fixed at the one-vector code
// - enable set means the legacy pin stays deasserted
// - message enable clears on reset
// - address bits 31:2 are writable and form the target address
// - address bits 1:0 always read zero
// - upper address is read/write, used only with wide capability
// - zero upper address gives a 32-bit address write
// - message data goes on the low payload word
`timescale 1ns/1ps
`default_nettype none
module mmc_msi_cap (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        cfg_wr,
   input  wire logic        cfg_rd,
   input  wire logic [1:0]  cfg_sel,
   input  wire logic [31:0] cfg_wdata,
   output logic      [31:0] cfg_rdata,
   output logic             cfg_rvalid,
   input  wire logic        irq_req,
   output logic             intx_out,
   output logic             mwr_valid,
   input  wire logic        mwr_ready,
   output logic      [63:0] mwr_addr,
   output logic             mwr_addr64,
   output logic      [31:0] mwr_data
);
   // ==========================================================
   // registers
   logic [15:0] ctrl_q;
   logic        msg_on;
   logic [31:0] addr_l_q;
   logic [31:0] addr_h_q;
   logic [15:0] data_q;

   mmc_ctrl_word u_ctrl (
      .clk     (clk),
      .rst     (rst),
      .wr_en   (cfg_wr && cfg_sel == mmc_pkg::SEL_CTRL),
      .wr_data (cfg_wdata[15:0]),
      .rd_data (ctrl_q),
      .msg_on  (msg_on)
   );
   mmc_data_reg #(
      .WIDTH (32),
      .WMASK (mmc_pkg::ADDR_L_WMASK),
      .RSTV  (mmc_pkg::ADDR_L_RESET)
   ) u_addr_l (
      .clk     (clk),
      .rst     (rst),
      .wr_en   (cfg_wr && cfg_sel == mmc_pkg::SEL_ADDR_L),
      .wr_data (cfg_wdata),
      .q       (addr_l_q)
   );
   mmc_data_reg #(
      .WIDTH (32),
      .RSTV  (mmc_pkg::ADDR_H_RESET)
   ) u_addr_h (
      .clk     (clk),
      .rst     (rst),
      .wr_en   (cfg_wr && cfg_sel == mmc_pkg::SEL_ADDR_H),
      .wr_data (cfg_wdata),
      .q       (addr_h_q)
   );
   mmc_data_reg #(
      .WIDTH (16),
      .RSTV  ({16'h0000, mmc_pkg::DATA_RESET})
   ) u_data (
      .clk     (clk),
      .rst     (rst),
      .wr_en   (cfg_wr && cfg_sel == mmc_pkg::SEL_DATA),
      .wr_data (cfg_wdata[15:0]),
      .q       (data_q)
   );

   // ==========================================================
   // read port, registered one cycle after the strobe
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic        rvalid_r;
   logic        rvalid_nxt;
   always_comb begin
      rvalid_nxt = cfg_rd;
      rdata_nxt  = rdata_r;
      if (cfg_rd) begin
         case (cfg_sel)
            mmc_pkg::SEL_CTRL:   rdata_nxt = {16'h0000, ctrl_q};
            mmc_pkg::SEL_ADDR_L: rdata_nxt = addr_l_q;
            mmc_pkg::SEL_ADDR_H: rdata_nxt = addr_h_q;
            mmc_pkg::SEL_DATA:   rdata_nxt = {16'h0000, data_q};
            default:             rdata_nxt = 32'h0000_0000;
         endcase
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_r  <= 32'h0000_0000;
         rvalid_r <= 1'b0;
      end else begin
         rdata_r  <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end
   assign cfg_rdata  = rdata_r;
   assign cfg_rvalid = rvalid_r;

   // ==========================================================
   // interrupt delivery: pin or message write
   mmc_pkg::mmc_state_type st_r;
   mmc_pkg::mmc_state_type st_nxt;
   logic        intx_r;
   logic        intx_nxt;
   logic        pend_r;
   logic        pend_nxt;
   logic        valid_r;
   logic        valid_nxt;
   logic [63:0] addr_r;
   logic [63:0] addr_nxt;
   logic        a64_r;
   logic        a64_nxt;
   logic [31:0] data_r;
   logic [31:0] data_nxt;
   logic        wide_use;
   always_comb begin
      // upper half used only when advertised and nonzero
      wide_use = ctrl_q[mmc_pkg::CTRL_WIDE_BIT]
                 && (addr_h_q != 32'h0000_0000);
      st_nxt    = st_r;
      valid_nxt = valid_r;
      addr_nxt  = addr_r;
      a64_nxt   = a64_r;
      data_nxt  = data_r;
      // a request seen while busy is held, not lost
      pend_nxt  = pend_r | (irq_req & msg_on);
      // pin follows the request only while messages are off
      intx_nxt  = irq_req & ~msg_on;
      case (st_r)
         mmc_pkg::ST_IDLE: begin
            if (msg_on && (pend_r || irq_req)) begin
               pend_nxt  = 1'b0;
               valid_nxt = 1'b1;
               st_nxt    = mmc_pkg::ST_SEND;
               addr_nxt  = {wide_use ? addr_h_q : 32'h0000_0000,
                            addr_l_q};
               a64_nxt   = wide_use;
               data_nxt  = {16'h0000, data_q};
            end else if (!msg_on) begin
               pend_nxt = 1'b0;
            end
         end
         mmc_pkg::ST_SEND: begin
            // write already launched completes even if disabled
            if (mwr_ready) begin
               valid_nxt = 1'b0;
               st_nxt    = mmc_pkg::ST_IDLE;
            end
         end
         default: begin
            valid_nxt = 1'b0;
            st_nxt    = mmc_pkg::ST_IDLE;
         end
      endcase
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         st_r    <= mmc_pkg::ST_IDLE;
         intx_r  <= 1'b0;
         pend_r  <= 1'b0;
         valid_r <= 1'b0;
         addr_r  <= 64'h0000_0000_0000_0000;
         a64_r   <= 1'b0;
         data_r  <= 32'h0000_0000;
      end else begin
         st_r    <= st_nxt;
         intx_r  <= intx_nxt;
         pend_r  <= pend_nxt;
         valid_r <= valid_nxt;
         addr_r  <= addr_nxt;
         a64_r   <= a64_nxt;
         data_r  <= data_nxt;
      end
   end
   assign intx_out   = intx_r;
   assign mwr_valid  = valid_r;
   assign mwr_addr   = addr_r;
   assign mwr_addr64 = a64_r;
   assign mwr_data   = data_r;
endmodule
`default_nettype wire

//--- shared/mmc_pkg.sv
package mmc_pkg;
   // ==========================================================
   // register select codes on the config port
   localparam logic [1:0] SEL_CTRL   = 2'h0;
   localparam logic [1:0] SEL_ADDR_L = 2'h1;
   localparam logic [1:0] SEL_ADDR_H = 2'h2;
   localparam logic [1:0] SEL_DATA   = 2'h3;
   // ==========================================================
   // control word fields
   localparam int CTRL_ENABLE_BIT  = 0;
   localparam int CTRL_REQ_LSB     = 1;
   localparam int CTRL_ALLOC_LSB   = 4;
   localparam int CTRL_WIDE_BIT    = 7;
   localparam logic [2:0] REQ_ONE_VECTOR   = 3'h0;
   localparam logic [2:0] ALLOC_RESET      = 3'h0;
   localparam logic [2:0] ALLOC_MAX_LEGAL  = 3'h5;
   localparam logic       WIDE_CAPABLE     = 1'b1;
   localparam logic       ENABLE_RESET     = 1'b0;
   localparam logic [31:0] ADDR_L_RESET    = 32'h0000_0000;
   localparam logic [31:0] ADDR_H_RESET    = 32'h0000_0000;
   localparam logic [15:0] DATA_RESET      = 16'h0000;
   localparam logic [31:0] ADDR_L_WMASK    = 32'hFFFF_FFFC;
   // ==========================================================
   // message write sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SEND = 2'b10
   } mmc_state_type;
endpackage

//--- sim/mmc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// host side: takes memory writes after a set stall
module mmc_host_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [3:0]  stall,
   input  wire logic        mwr_valid,
   input  wire logic [63:0] mwr_addr,
   input  wire logic        mwr_addr64,
   input  wire logic [31:0] mwr_data,
   output logic             mwr_ready,
   output logic      [63:0] got_addr,
   output logic             got_a64,
   output logic      [31:0] got_data,
   output logic      [7:0]  got_n
);
   logic [3:0] wait_r;
   always_ff @(posedge clk) begin
      mwr_ready <= 1'b0;
      if (rst) begin
         wait_r <= 4'h0;
         got_n <= 8'h0;
      end else if (mwr_valid && mwr_ready) begin
         got_addr <= mwr_addr;
         got_a64 <= mwr_addr64;
         got_data <= mwr_data;
         got_n <= got_n + 8'h1;
         wait_r <= 4'h0;
      end else if (mwr_valid) begin
         // slow answer: ready only after stall cycles
         if (wait_r >= stall) mwr_ready <= 1'b1;
         else wait_r <= wait_r + 4'h1;
      end
   end
endmodule
`default_nettype wire

//--- sim/mmc_props_properties.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// checker
module mmc_props (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        cfg_rd,
   input wire logic [1:0]  cfg_sel,
   input wire logic [31:0] cfg_rdata,
   input wire logic        cfg_rvalid,
   input wire logic        irq_req,
   input wire logic        intx_out,
   input wire logic        mwr_valid,
   input wire logic        mwr_ready,
   input wire logic [63:0] mwr_addr,
   input wire logic        mwr_addr64,
   input wire logic [31:0] mwr_data
);
   logic ctl_rd_r;
   logic lo_rd_r;
   // read kind is remembered so the answer cycle knows what it shows
   always_ff @(posedge clk) begin
      ctl_rd_r <= cfg_rd && cfg_sel == mmc_pkg::SEL_CTRL;
      lo_rd_r  <= cfg_rd && cfg_sel == mmc_pkg::SEL_ADDR_L;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   AST_CTL_RSV: assert property (ctl_rd_r |-> cfg_rvalid &&
      cfg_rdata[31:8] == 24'h0) else $error("control upper byte set");
   AST_CTL_WIDE: assert property (ctl_rd_r |-> cfg_rdata[7])
      else $error("wide flag clear");
   AST_CTL_REQ: assert property (ctl_rd_r |-> cfg_rdata[3:1] == 3'h0)
      else $error("requested count wrong");
   AST_ADR_LOW: assert property (lo_rd_r |-> cfg_rdata[1:0] == 2'h0)
      else $error("address low bits set");
   AST_INTX: assert property (intx_out |-> $past(irq_req))
      else $error("pin without request");
   AST_A64: assert property (mwr_valid |->
      mwr_addr64 == (mwr_addr[63:32] != 32'h0)) else $error("addr64 wrong");
   AST_PAYLOAD: assert property (mwr_valid |->
      mwr_data[31:16] == 16'h0 && mwr_addr[1:0] == 2'h0)
      else $error("payload or address form wrong");
   AST_HOLD: assert property (mwr_valid && !mwr_ready |=> mwr_valid &&
      $stable(mwr_data) && $stable(mwr_addr)) else $error("write not held");
   AST_DROP: assert property (mwr_valid && mwr_ready |=> !mwr_valid)
      else $error("write not dropped");
   COV_MSG: cover property (mwr_valid && mwr_ready);
   COV_A64: cover property (mwr_valid && mwr_addr64);
   COV_PIN: cover property ($rose(intx_out));
endmodule
bind mmc_msi_cap mmc_props u_props (.clk(clk), .rst(rst),
   .cfg_rd(cfg_rd), .cfg_sel(cfg_sel), .cfg_rdata(cfg_rdata),
   .cfg_rvalid(cfg_rvalid), .irq_req(irq_req), .intx_out(intx_out),
   .mwr_valid(mwr_valid), .mwr_ready(mwr_ready), .mwr_addr(mwr_addr),
   .mwr_addr64(mwr_addr64), .mwr_data(mwr_data));
`default_nettype wire

//--- sim/test_mmc_msi_cap.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// bench
module test_mmc_msi_cap;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        cfg_wr = 1'b0;
   logic        cfg_rd = 1'b0;
   logic        irq_req = 1'b0;
   logic [1:0]  cfg_sel = 2'h0;
   logic [31:0] cfg_wdata = 32'h0;
   logic [3:0]  stall = 4'h0;
   logic [31:0] cfg_rdata, mwr_data, got_data;
   logic [63:0] mwr_addr, got_addr;
   logic [7:0]  got_n;
   logic        cfg_rvalid, intx_out, mwr_valid, mwr_ready;
   logic        mwr_addr64, got_a64;
   int          bad_count = 0;
   int          checks = 0;
   always #5 clk = ~clk;
   mmc_msi_cap DUT (.clk(clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
      .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .cfg_rvalid(cfg_rvalid), .irq_req(irq_req), .intx_out(intx_out),
      .mwr_valid(mwr_valid), .mwr_ready(mwr_ready), .mwr_addr(mwr_addr),
      .mwr_addr64(mwr_addr64), .mwr_data(mwr_data));
   mmc_host_model host (.clk(clk), .rst(rst), .stall(stall),
      .mwr_valid(mwr_valid), .mwr_ready(mwr_ready), .mwr_addr(mwr_addr),
      .mwr_addr64(mwr_addr64), .mwr_data(mwr_data), .got_addr(got_addr),
      .got_a64(got_a64), .got_data(got_data), .got_n(got_n));
   task chk(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task test_done;
      $display("checks %0d bad %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task wr(input logic [1:0] s, input logic [31:0] d);
      @(posedge clk);
      cfg_wr <= 1'b1;
      cfg_sel <= s;
      cfg_wdata <= d;
      @(posedge clk);
      cfg_wr <= 1'b0;
   endtask
   task rd(input logic [1:0] s, input logic [31:0] e);
      @(posedge clk);
      cfg_rd <= 1'b1;
      cfg_sel <= s;
      @(posedge clk);
      cfg_rd <= 1'b0;
      #1 chk(64'(cfg_rvalid), 64'h1);
      chk(64'(cfg_rdata), 64'(e));
   endtask
   task t_ctrl;
      rd(mmc_pkg::SEL_CTRL, 32'h0000_0080);
      for (int a = 0; a < 6; a++) begin
         wr(mmc_pkg::SEL_CTRL, 32'h0000_FF0E | 32'(a) << 4);
         rd(mmc_pkg::SEL_CTRL, 32'h0000_0080 | 32'(a) << 4);
      end
   endtask
   task t_regs;
      wr(mmc_pkg::SEL_ADDR_L, 32'hFFFF_FFFF);
      rd(mmc_pkg::SEL_ADDR_L, 32'hFFFF_FFFC);
      wr(mmc_pkg::SEL_ADDR_H, 32'hA5A5_5A5A);
      rd(mmc_pkg::SEL_ADDR_H, 32'hA5A5_5A5A);
      wr(mmc_pkg::SEL_DATA, 32'h0000_C3A5);
      rd(mmc_pkg::SEL_DATA, 32'h0000_C3A5);
   endtask
   task t_pin;
      @(posedge clk);
      irq_req <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk(64'(intx_out), 64'h1);
      chk(64'(mwr_valid), 64'h0);
      @(posedge clk);
      irq_req <= 1'b0;
   endtask
   task t_msg(input logic [31:0] hi, input logic [3:0] st);
      logic [7:0] n;
      n = got_n + 8'h1;
      stall <= st;
      wr(mmc_pkg::SEL_ADDR_H, hi);
      wr(mmc_pkg::SEL_ADDR_L, 32'hFEE0_1007);
      wr(mmc_pkg::SEL_DATA, 32'h0000_4321);
      wr(mmc_pkg::SEL_CTRL, 32'h0000_0051);
      @(posedge clk);
      irq_req <= 1'b1;
      @(posedge clk);
      irq_req <= 1'b0;
      // request seen while enabled: pin quiet, write launched
      #1 chk(64'(intx_out), 64'h0);
      chk(64'(mwr_valid), 64'h1);
      for (int i = 0; i < 40 && got_n !== n; i++) @(posedge clk);
      #1 chk(got_addr, {hi, 32'hFEE0_1004});
      chk(64'(got_a64), 64'(hi != 32'h0));
      chk(64'(got_data), 64'h4321);
      chk(64'(intx_out), 64'h0);
      // a single pulse must give exactly one write
      repeat (6) @(posedge clk);
      #1 chk(64'(got_n), 64'(n));
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_ctrl;
      t_regs;
      t_pin;
      t_msg(32'h0, 4'h3);
      t_msg(32'h0000_0001, 4'h0);
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      rd(mmc_pkg::SEL_CTRL, 32'h0000_0080);
      test_done;
   end
   initial begin
      repeat (3000) @(posedge clk);
      bad_count++;
      test_done;
   end
endmodule
`default_nettype wire
